// [ewb_ctrl.sv]
/*
 Wait-state, break and prototype gating control of the emulator.
 Assumes straps are static, all inputs synchronous to core_clk, and a
 register master that never issues read and write strobes together.
*/
`timescale 1ns/1ns
module ewb_ctrl
    import ewb_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_BRK_CYC
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Straps
    input wire ewb_straps_t straps_in,
    // Emulator state
    input wire logic [1:0] emu_mode,
    input wire logic cpu_halted,
    input wire logic internal_op,
    input wire logic trace_evt,
    input wire logic break_req,
    input wire logic ext_hold,
    // Program memory access
    input wire ewb_acc_t acc,
    input wire logic pm_rd_valid,
    input wire logic [15:0] pm_rdata,
    output logic cpu_ready,
    // Prototype side
    input wire logic sync_ready_in,
    input wire logic async_ready_in,
    input wire logic proto_hold_req,
    output logic cpu_hold_req,
    output logic proto_cycle_start,
    output logic proto_data_oe_n,
    output logic [15:0] proto_data,
    // Indicators and break
    output logic trigger_trace_analyzer,
    output logic halted_indicator,
    output logic break_out,
    output logic error_out,
    // Register port
    input wire ewb_reg_req_t reg_req,
    output logic [DATA_W-1:0] reg_rdata,
    output logic irq
);
    typedef enum logic {ACC_IDLE, ACC_WAIT} ewb_acc_st_t;

    typedef struct packed {
        ewb_acc_st_t acc_st;
        logic [3:0] need;
        logic [3:0] thr;
        logic faulted;
        logic brk_pend;
        logic [HOLD_CNT_W-1:0] hold_cnt;
        logic break_o;
        logic error_o;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic [DATA_W-1:0] rdata;
        ewb_straps_t straps;
        logic halted;
        logic trace;
        ewb_proto_t proto;
    } ewb_state_t;

    localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYC - 1);

    ewb_state_t s;
    ewb_state_t next_s;
    logic [CNT_W-1:0] cnt;
    logic cnt_clr;
    logic cnt_inc;
    logic own_ok;
    logic proto_ok;
    logic fault_hit;
    logic acc_done;
    logic fire;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] w1c;
    logic [CNT_W-1:0] fault_at;

    ewb_wait_cnt u_cnt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clr(cnt_clr),
        .inc(cnt_inc),
        .cnt(cnt)
    );

    // Access readiness terms
    always_comb begin
        own_ok = cnt >= {1'b0, s.need}; // [R4] [R5]
        proto_ok = 1'b1;
        if (emu_mode == EMU_MODE_1) begin
            proto_ok = (!s.straps.sync_ready_control_strap || sync_ready_in) &&
                (!s.straps.async_ready_control_strap || async_ready_in); // [R12]
        end
        fault_at = {1'b0, s.need} + {1'b0, s.thr};
        fault_hit = s.acc_st == ACC_WAIT && s.thr != 4'h0 && !proto_ok &&
            cnt >= fault_at; // [R16]
    end

    always_comb begin
        next_s = s;
        ev = '0;
        cnt_clr = 1'b0;
        cnt_inc = 1'b0;
        acc_done = 1'b0;
        fire = 1'b0;
        next_s.straps = straps_in; // [R17]
        next_s.halted = cpu_halted; // [R6]
        next_s.trace = trace_evt &&
            (emu_mode != EMU_MODE_3 || s.straps.trace_strobe_strap); // [R1]
        next_s.proto.cycle_start = 1'b0;
        unique case (s.acc_st)
            ACC_IDLE: begin
                if (acc.start) begin
                    next_s.acc_st = ACC_WAIT;
                    next_s.need = ewb_waits(s.straps, acc.slow); // [R4] [R5]
                    next_s.thr = ewb_thresh(s.straps.ready_fault_threshold_strap); // [R16]
                    next_s.faulted = 1'b0;
                    cnt_clr = 1'b1;
                    next_s.proto.cycle_start = emu_mode == EMU_MODE_1; // [R11]
                    if (acc.write && acc.protect && !s.straps.protected_write_break_strap) begin
                        ev[EV_PROT] = 1'b1; // [R2]
                    end
                    if (acc.unalloc && !s.straps.missing_memory_break_strap) begin
                        ev[EV_MISS] = 1'b1; // [R3]
                    end
                end
            end
            ACC_WAIT: begin
                if (fault_hit && !s.faulted) begin
                    next_s.faulted = 1'b1;
                    ev[EV_RDYF] = 1'b1;
                end
                if (own_ok && (proto_ok || (fault_hit && s.straps.ready_timeout_strap))) begin
                    acc_done = 1'b1; // [R15]
                    next_s.acc_st = ACC_IDLE;
                end else begin
                    cnt_inc = 1'b1;
                end
            end
        endcase
        // Deferred break request around external hold
        if (s.brk_pend) begin
            if (!ext_hold) begin
                fire = 1'b1; // [R7]
            end else if (s.straps.hold_break_strap && s.hold_cnt == HOLD_LAST) begin
                fire = 1'b1; // [R8]
            end else begin
                next_s.hold_cnt = s.hold_cnt + 1'b1;
            end
        end
        if (fire) begin
            next_s.brk_pend = 1'b0;
            ev[EV_BRK] = 1'b1;
        end
        if (break_req && !s.brk_pend) begin
            next_s.brk_pend = 1'b1;
            next_s.hold_cnt = '0;
        end
        ev[EV_HALT] = cpu_halted && !s.halted;
        next_s.break_o = ev[EV_PROT] || ev[EV_MISS] || ev[EV_BRK] ||
            (ev[EV_RDYF] && !s.straps.ready_fault_break_strap); // [R2] [R3] [R13]
        next_s.error_o = ev[EV_MISS] ||
            (ev[EV_RDYF] && !s.straps.ready_fault_break_strap); // [R3] [R13]
        // Data path towards the prototype
        if (emu_mode == EMU_MODE_1 && s.straps.prototype_data_path_strap && pm_rd_valid) begin
            next_s.proto.data = pm_rdata; // [R10] [R14]
            next_s.proto.data_oe_n = 1'b0;
        end else begin
            next_s.proto.data_oe_n = 1'b1;
        end
        // Register port, set wins over clear
        w1c = '0;
        if (reg_req.wr && reg_req.addr == REG_STATUS) begin
            w1c = reg_req.wdata[EV_W-1:0];
        end
        if (reg_req.wr && reg_req.addr == REG_MASK) begin
            next_s.mask = reg_req.wdata[EV_W-1:0];
        end
        next_s.status = (s.status & ~w1c) | ev;
        next_s.rdata = '0;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                REG_STATUS: next_s.rdata = {3'h0, s.status};
                REG_MASK: next_s.rdata = {3'h0, s.mask};
                REG_STRAPS: next_s.rdata = {s.straps.wait_count_strap,
                    s.straps.wait_mode_strap, s.straps.ready_fault_threshold_strap,
                    s.straps.ready_timeout_strap};
                REG_STATE: next_s.rdata = {cnt[3:0], s.brk_pend, s.faulted,
                    s.halted, s.acc_st == ACC_WAIT};
                default: next_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.acc_st <= ACC_IDLE;
            s.status <= STATUS_RST;
            s.mask <= MASK_RST;
            s.proto.data_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign cpu_ready = acc_done;
    assign cpu_hold_req = proto_hold_req &&
        !(emu_mode == EMU_MODE_3 && internal_op && s.straps.user_hold_gate_strap); // [R9]
    assign proto_cycle_start = s.proto.cycle_start;
    assign proto_data_oe_n = s.proto.data_oe_n;
    assign proto_data = s.proto.data;
    assign trigger_trace_analyzer = s.trace;
    assign halted_indicator = s.halted;
    assign break_out = s.break_o;
    assign error_out = s.error_o;
    assign reg_rdata = s.rdata;
    assign irq = |(s.status & s.mask);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic start_idle;
    assign start_idle = acc.start && s.acc_st == ACC_IDLE;

    chk_trace_gate: assert property ( // [R1]
        trace_evt && emu_mode == EMU_MODE_3 && !s.straps.trace_strobe_strap
        |=> !trigger_trace_analyzer)
        else $error("trace strobe in mode 3 while suppressed");
    chk_prot_break: assert property ( // [R2]
        start_idle && acc.write && acc.protect && !s.straps.protected_write_break_strap
        |=> break_out && s.status[EV_PROT])
        else $error("protected write did not break");
    chk_miss_error: assert property ( // [R3]
        start_idle && acc.unalloc && !s.straps.missing_memory_break_strap
        |=> break_out && error_out)
        else $error("missing memory did not break with error");
    chk_no_wait: assert property ( // [R4]
        start_idle && s.straps.wait_mode_strap == WAIT_NONE && emu_mode != EMU_MODE_1
        |=> cpu_ready)
        else $error("wait states inserted in no-wait mode");
    chk_wait_two: assert property ( // [R5]
        start_idle && s.straps.wait_mode_strap == WAIT_ALL &&
        s.straps.wait_count_strap == 3'h1 && emu_mode != EMU_MODE_1 && $stable(s.straps)
        |=> !cpu_ready ##1 !cpu_ready ##1 cpu_ready)
        else $error("position one did not give two waits");
    chk_halt_led: assert property ( // [R6]
        cpu_halted |=> halted_indicator ##0 $past(cpu_halted) == halted_indicator)
        else $error("halted indicator wrong");
    chk_hold_defer: assert property ( // [R7]
        s.brk_pend && ext_hold && !s.straps.hold_break_strap |=> !break_out)
        else $error("break taken during hold");
    chk_hold_timeout: assert property ( // [R8]
        s.brk_pend && ext_hold && s.straps.hold_break_strap && s.hold_cnt == HOLD_LAST
        |=> break_out && !s.brk_pend)
        else $error("timed hold break missing");
    chk_user_hold: assert property ( // [R9]
        emu_mode == EMU_MODE_3 && internal_op && s.straps.user_hold_gate_strap
        |-> !cpu_hold_req)
        else $error("user hold not masked");
    chk_data_path: assert property ( // [R10]
        emu_mode == EMU_MODE_1 && s.straps.prototype_data_path_strap && pm_rd_valid
        |=> !proto_data_oe_n && proto_data == $past(pm_rdata))
        else $error("data path not driven");
    chk_data_off: assert property ( // [R10]
        !s.straps.prototype_data_path_strap |=> proto_data_oe_n)
        else $error("data path driven while disabled");
    chk_proto_cycle: assert property ( // [R11]
        start_idle && emu_mode == EMU_MODE_1 |=> proto_cycle_start)
        else $error("no prototype cycle in mode 1");
    chk_rdy_extend: assert property ( // [R12]
        s.acc_st == ACC_WAIT && emu_mode == EMU_MODE_1 &&
        s.straps.sync_ready_control_strap && !sync_ready_in && !fault_hit
        |-> !cpu_ready)
        else $error("access ended without prototype ready");
    chk_fault_break: assert property ( // [R13]
        ev[EV_RDYF] && !s.straps.ready_fault_break_strap |=> break_out && error_out)
        else $error("ready fault did not break");
    chk_timeout_force: assert property ( // [R15]
        own_ok && fault_hit && s.straps.ready_timeout_strap |-> cpu_ready)
        else $error("timeout did not force ready");
    chk_fault_thr: assert property ( // [R16]
        ev[EV_RDYF] |-> (s.thr == THR_SEL1 || s.thr == THR_SEL2 || s.thr == THR_SEL3))
        else $error("fault with illegal threshold");
    chk_strap_sample: assert property ( // [R17]
        rst_n |=> s.straps == $past(straps_in))
        else $error("straps not sampled");

    cov_mode1_access: cover property (start_idle && emu_mode == EMU_MODE_1 ##[1:20] cpu_ready);
    cov_ready_fault: cover property (ev[EV_RDYF]);
    cov_hold_break: cover property (s.brk_pend && ext_hold ##1 break_out);
    cov_irq: cover property (irq);
endmodule

// [ewb_pkg.sv]
/*
 Constants, types and helper decoders for the emulator wait and break control.
 Assumes one 10 MHz processor clock and straps that only change while powered down.
*/
// Behaviour
// R1: Trace strobes in mode 3 only when strapped.
// R2: Break on protected write unless disabled.
// R3: Break and error on unallocated access.
// R4: Waits on slow locations, all, or none.
// R5: Count position n gives n plus one waits; position zero gives two.
// R6: Halted indicator follows processor halted state.
// R7: Default: break deferred until hold ends.
// R8: Option: break after half second during hold.
// R9: Mode 3 internal operations may mask user hold.
// R10: Option drives memory read data to prototype.
// R11: Mode 1 mirrors each access on prototype bus.
// R12: Straps let prototype readies extend mode 1 accesses.
// R13: Ready fault breaks with error unless disabled.
// R14: Prototype buffers stay off while device drives.
// R15: Timeout option forces ready after threshold waits.
// R16: Fault threshold selects zero, one, four, eight.
// R17: Straps sampled every clock, assumed static.
package ewb_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int HOLD_BRK_DELAY_MS = 500;
    localparam int HOLD_BRK_CYC = HOLD_BRK_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W = 23;
    localparam int CNT_W = 5;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int EV_W = 5;

    localparam logic [1:0] EMU_MODE_1 = 2'h1;
    localparam logic [1:0] EMU_MODE_3 = 2'h3;
    localparam logic [1:0] WAIT_SLOW = 2'h0;
    localparam logic [1:0] WAIT_ALL = 2'h1;
    localparam logic [1:0] WAIT_NONE = 2'h2;
    localparam logic [3:0] THR_SEL0 = 4'h0;
    localparam logic [3:0] THR_SEL1 = 4'h1;
    localparam logic [3:0] THR_SEL2 = 4'h4;
    localparam logic [3:0] THR_SEL3 = 4'h8;

    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h1;
    localparam logic [3:0] REG_STRAPS = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [4:0] MASK_RST = 5'h00;

    localparam int EV_PROT = 0;
    localparam int EV_MISS = 1;
    localparam int EV_RDYF = 2;
    localparam int EV_BRK = 3;
    localparam int EV_HALT = 4;

    typedef struct packed {
        logic trace_strobe_strap;
        logic protected_write_break_strap;
        logic missing_memory_break_strap;
        logic [1:0] wait_mode_strap;
        logic [2:0] wait_count_strap;
        logic hold_break_strap;
        logic user_hold_gate_strap;
        logic prototype_data_path_strap;
        logic sync_ready_control_strap;
        logic async_ready_control_strap;
        logic ready_fault_break_strap;
        logic ready_timeout_strap;
        logic [1:0] ready_fault_threshold_strap;
    } ewb_straps_t;

    typedef struct packed {
        logic start;
        logic write;
        logic slow;
        logic protect;
        logic unalloc;
    } ewb_acc_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ewb_reg_req_t;

    typedef struct packed {
        logic cycle_start;
        logic data_oe_n;
        logic [15:0] data;
    } ewb_proto_t;

    // Wait states owed by one program-memory access
    function automatic logic [3:0] ewb_waits(input ewb_straps_t st, input logic slow);
        logic [3:0] n;
        n = {1'b0, st.wait_count_strap} + 4'h1;
        if (st.wait_count_strap == 3'h0) begin
            n = 4'h2;
        end
        unique case (st.wait_mode_strap)
            WAIT_SLOW: ewb_waits = slow ? n : 4'h0;
            WAIT_ALL: ewb_waits = n;
            default: ewb_waits = 4'h0;
        endcase
    endfunction

    // Waits on prototype ready before a fault
    function automatic logic [3:0] ewb_thresh(input logic [1:0] sel);
        unique case (sel)
            2'h0: ewb_thresh = THR_SEL0;
            2'h1: ewb_thresh = THR_SEL1;
            2'h2: ewb_thresh = THR_SEL2;
            default: ewb_thresh = THR_SEL3;
        endcase
    endfunction
endpackage

// [ewb_wait_cnt.sv]
/*
 Saturating wait-state counter of the access sequencer.
 Assumes the owner clears it at each access start.
*/
`timescale 1ns/1ns
module ewb_wait_cnt
    import ewb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic inc,
    // Count
    output logic [CNT_W-1:0] cnt
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } ewb_cnt_st_t;

    ewb_cnt_st_t s;
    ewb_cnt_st_t next_s;

    always_comb begin
        next_s = s;
        if (clr) begin
            next_s.cnt = '0;
        end else if (inc && s.cnt != '1) begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cnt = s.cnt;
endmodule

// [ewb_proto_model.sv]
/*
 Model of the user prototype bus at the processor socket.
 Assumes one clock; the bench sets the ready delay and the hold request.
*/
`timescale 1ns/1ns
module ewb_proto_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Device side
    input wire logic proto_cycle_start,
    input wire logic proto_data_oe_n,
    input wire logic [15:0] proto_data,
    output logic sync_ready_in,
    output logic async_ready_in,
    output logic proto_hold_req,
    // Bench control
    input wire logic [3:0] rdy_delay,
    input wire logic hold_cmd,
    output logic buf_oe_n,
    output logic [15:0] seen_data
);
    logic busy;
    logic [3:0] wait_left;
    logic rdy;

    assign proto_hold_req = hold_cmd;
    // Ready pulse once the delay runs out; 4'hF never answers
    assign rdy = busy && (wait_left == 4'h0);
    assign sync_ready_in = rdy;
    assign async_ready_in = rdy;
    // Own buffers off while the device drives
    assign buf_oe_n = !proto_data_oe_n;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            wait_left <= 4'h0;
            seen_data <= 16'h0000;
        end else begin
            if (proto_cycle_start) begin
                busy <= 1'b1;
                wait_left <= rdy_delay;
            end else if (rdy) begin
                busy <= 1'b0;
            end else if (busy && wait_left != 4'hF) begin
                wait_left <= wait_left - 4'h1;
            end
            if (!proto_data_oe_n) begin
                seen_data <= proto_data;
            end
        end
    end
endmodule

// [ewb_ctrl_tb.sv]
/*
 Self-checking bench for the wait, break and prototype control.
 Assumes the design's package and a prototype model beside it.
*/
`timescale 1ns/1ns
module ewb_ctrl_tb;
    import ewb_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    ewb_straps_t straps = '0;
    logic [1:0] emu_mode = 2'h0;
    logic cpu_halted = 1'b0;
    logic internal_op = 1'b0;
    logic trace_evt = 1'b0;
    logic break_req = 1'b0;
    logic ext_hold = 1'b0;
    ewb_acc_t acc = '0;
    logic pm_rd_valid = 1'b0;
    logic [15:0] pm_rdata = 16'h0000;
    ewb_reg_req_t reg_req = '0;
    logic [3:0] rdy_delay = 4'h0;
    logic hold_cmd = 1'b0;
    logic cpu_ready, sync_ready_in, async_ready_in, proto_hold_req, cpu_hold_req;
    logic proto_cycle_start, proto_data_oe_n, trigger_trace_analyzer;
    logic halted_indicator, break_out, error_out, irq, buf_oe_n;
    logic [15:0] proto_data, seen_data;
    logic [DATA_W-1:0] reg_rdata;
    int fails = 0;
    int n_checks = 0;
    int n_brk = 0;
    int n_err = 0;
    int n_pcs = 0;

    always #50 core_clk = !core_clk;

    ewb_ctrl #(.HOLD_CYC(8)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .straps_in(straps),
        .emu_mode(emu_mode), .cpu_halted(cpu_halted), .internal_op(internal_op),
        .trace_evt(trace_evt), .break_req(break_req), .ext_hold(ext_hold), .acc(acc),
        .pm_rd_valid(pm_rd_valid), .pm_rdata(pm_rdata), .cpu_ready(cpu_ready),
        .sync_ready_in(sync_ready_in), .async_ready_in(async_ready_in),
        .proto_hold_req(proto_hold_req), .cpu_hold_req(cpu_hold_req),
        .proto_cycle_start(proto_cycle_start), .proto_data_oe_n(proto_data_oe_n),
        .proto_data(proto_data), .trigger_trace_analyzer(trigger_trace_analyzer),
        .halted_indicator(halted_indicator), .break_out(break_out), .error_out(error_out),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));

    ewb_proto_model i_proto (.core_clk(core_clk), .rst_n(rst_n),
        .proto_cycle_start(proto_cycle_start), .proto_data_oe_n(proto_data_oe_n),
        .proto_data(proto_data), .sync_ready_in(sync_ready_in),
        .async_ready_in(async_ready_in), .proto_hold_req(proto_hold_req),
        .rdy_delay(rdy_delay), .hold_cmd(hold_cmd), .buf_oe_n(buf_oe_n),
        .seen_data(seen_data));

    // Pulse counters
    always @(posedge core_clk) begin
        n_brk += int'(break_out === 1'b1);
        n_err += int'(error_out === 1'b1);
        n_pcs += int'(proto_cycle_start === 1'b1);
    end

    task automatic test_done();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask

    task automatic setup(input ewb_straps_t s);
        @(posedge core_clk);
        straps <= s;
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        n_brk = 0;
        n_err = 0;
    endtask

    task automatic access(input logic w, s, p, u, output int cyc);
        n_brk = 0;
        n_err = 0;
        n_pcs = 0;
        @(posedge core_clk);
        acc <= {1'b1, w, s, p, u};
        @(posedge core_clk);
        acc <= '0;
        cyc = 1;
        #1;
        while (cpu_ready !== 1'b1 && cyc < 40) begin
            @(posedge core_clk);
            #1;
            cyc++;
        end
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= {1'b1, 1'b0, a, d};
        @(posedge core_clk);
        reg_req <= '0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        d = reg_rdata;
    endtask

    task automatic t_waits();
        ewb_straps_t s;
        int cyc;
        s = '0;
        s.wait_mode_strap = WAIT_ALL;
        for (int n = 1; n < 8; n++) begin
            s.wait_count_strap = 3'(n);
            setup(s);
            access(1'b0, 1'b0, 1'b0, 1'b0, cyc);
            chk("waits_all", n + 2, cyc);
        end
        s.wait_count_strap = 3'h3;
        s.wait_mode_strap = WAIT_SLOW;
        setup(s);
        access(1'b0, 1'b1, 1'b0, 1'b0, cyc);
        chk("waits_slow", 5, cyc);
        access(1'b0, 1'b0, 1'b0, 1'b0, cyc);
        chk("waits_fast", 1, cyc);
        s.wait_mode_strap = WAIT_NONE;
        setup(s);
        access(1'b0, 1'b1, 1'b0, 1'b0, cyc);
        chk("waits_none", 1, cyc);
    endtask

    task automatic t_breaks();
        ewb_straps_t s;
        int cyc;
        logic [7:0] d;
        s = '0;
        setup(s);
        access(1'b1, 1'b0, 1'b1, 1'b0, cyc);
        chk("prot_break", 1, n_brk);
        reg_rd(REG_STATUS, d);
        chk("status_prot", 8'h01, d);
        chk("irq_masked", 0, irq);
        reg_wr(REG_MASK, 8'h1F);
        reg_rd(REG_MASK, d);
        chk("mask_rb", 8'h1F, d);
        chk("irq_set", 1, irq);
        reg_wr(REG_STATUS, 8'h01);
        reg_rd(REG_STATUS, d);
        chk("status_clr", 8'h00, d);
        chk("irq_clr", 0, irq);
        reg_rd(4'hF, d);
        chk("unmapped", 8'h00, d);
        access(1'b0, 1'b0, 1'b0, 1'b1, cyc);
        chk("miss_break", 1, n_brk);
        chk("miss_err", 1, n_err);
        s.protected_write_break_strap = 1'b1;
        s.missing_memory_break_strap = 1'b1;
        setup(s);
        access(1'b1, 1'b0, 1'b1, 1'b1, cyc);
        chk("no_break", 0, n_brk + n_err);
    endtask

    task automatic t_fault();
        ewb_straps_t s;
        int cyc;
        int thr;
        logic [7:0] d;
        emu_mode <= EMU_MODE_1;
        rdy_delay <= 4'hF;
        s = '0;
        s.wait_mode_strap = WAIT_NONE;
        s.sync_ready_control_strap = 1'b1;
        s.ready_timeout_strap = 1'b1;
        for (int i = 1; i < 4; i++) begin
            thr = (i == 1) ? 1 : ((i == 2) ? 4 : 8);
            s.ready_fault_threshold_strap = 2'(i);
            s.ready_fault_break_strap = (i == 3);
            setup(s);
            access(1'b0, 1'b0, 1'b0, 1'b0, cyc);
            chk("fault_timeout", 1, cyc > thr && cyc <= thr + 3);
            chk("fault_break", i != 3, n_brk);
            chk("fault_err", i != 3, n_err);
            reg_rd(REG_STRAPS, d);
            chk("straps_rb", 8'h11 + 2 * i, d);
        end
        s.ready_fault_threshold_strap = 2'h0;
        setup(s);
        access(1'b0, 1'b0, 1'b0, 1'b0, cyc);
        chk("no_fault_wait", 40, cyc);
    endtask

    task automatic t_ready();
        ewb_straps_t s;
        int cyc;
        emu_mode <= EMU_MODE_1;
        rdy_delay <= 4'h3;
        for (int i = 0; i < 3; i++) begin
            s = '0;
            s.wait_mode_strap = WAIT_NONE;
            s.sync_ready_control_strap = (i == 1);
            s.async_ready_control_strap = (i == 2);
            setup(s);
            access(1'b0, 1'b0, 1'b0, 1'b0, cyc);
            chk("ready_ext", 1, (i == 0) ? cyc == 1 : cyc >= 4 && cyc <= 8);
            chk("proto_cycles", 1, n_pcs);
        end
    endtask

    task automatic t_data();
        ewb_straps_t s;
        emu_mode <= EMU_MODE_1;
        s = '0;
        for (int i = 0; i < 2; i++) begin
            s.prototype_data_path_strap = i[0];
            setup(s);
            @(posedge core_clk);
            pm_rd_valid <= 1'b1;
            pm_rdata <= 16'hA5C3;
            @(posedge core_clk);
            pm_rd_valid <= 1'b0;
            #1;
            chk("data_oe_n", i == 0, proto_data_oe_n);
            @(posedge core_clk);
            #1;
            chk("seen_data", (i == 1) ? 16'hA5C3 : 16'h0000, seen_data);
        end
    endtask

    task automatic t_hold();
        ewb_straps_t s;
        emu_mode <= 2'h0;
        s = '0;
        for (int i = 0; i < 2; i++) begin
            s.hold_break_strap = i[0];
            setup(s);
            @(posedge core_clk);
            ext_hold <= 1'b1;
            break_req <= 1'b1;
            @(posedge core_clk);
            break_req <= 1'b0;
            repeat (5) @(posedge core_clk);
            #1;
            chk("hold_early", 0, n_brk);
            repeat ((i == 1) ? 8 : 20) @(posedge core_clk);
            #1;
            chk("hold_break", i, n_brk);
            @(posedge core_clk);
            ext_hold <= 1'b0;
            repeat (4) @(posedge core_clk);
            #1;
            chk("hold_end", 1, n_brk);
        end
    endtask

    task automatic t_misc();
        ewb_straps_t s;
        logic [7:0] d;
        emu_mode <= EMU_MODE_3;
        s = '0;
        for (int i = 0; i < 2; i++) begin
            s.trace_strobe_strap = i[0];
            s.user_hold_gate_strap = i[0];
            setup(s);
            @(posedge core_clk);
            trace_evt <= 1'b1;
            internal_op <= 1'b1;
            hold_cmd <= 1'b1;
            @(posedge core_clk);
            trace_evt <= 1'b0;
            #1;
            chk("trace_strobe", i, trigger_trace_analyzer);
            chk("user_hold", i == 0, cpu_hold_req);
            @(posedge core_clk);
            internal_op <= 1'b0;
            #1;
            chk("user_hold_idle", 1, cpu_hold_req);
            @(posedge core_clk);
            hold_cmd <= 1'b0;
        end
        cpu_halted <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("halted", 1, halted_indicator);
        reg_rd(REG_STATUS, d);
        chk("halt_status", 8'h10, d);
        @(posedge core_clk);
        cpu_halted <= 1'b0;
    endtask

    initial begin
        t_waits();
        t_breaks();
        t_fault();
        t_ready();
        t_data();
        t_hold();
        t_misc();
        test_done();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        test_done();
    end
endmodule
